/* design/mlsu_pkg.sv */
/*
 * Constants, encodings and state type for the serial update block of a
 * pixel-memory display. Assumes a single system clock domain; everything
 * arriving from the host is asynchronous to it.
 */
package mlsu_pkg;
    localparam int          BYTE_BITS      = 8;
    localparam int          LINE_COUNT     = 168;
    localparam int          LINE_BYTES     = 18;
    localparam int          FIFO_DEPTH     = 8;
    localparam int          FIFO_WIDTH     = 9;
    localparam int          SYNC_STAGES    = 2;
    localparam int          HDR_UPDATE_BIT = 0;
    localparam int          HDR_POL_BIT    = 1;
    localparam int          HDR_CLEAR_BIT  = 2;
    localparam int          MARK_BIT       = 8;
    localparam logic [7:0]  FIRST_LINE     = 8'h01;
    localparam logic [7:0]  LAST_LINE      = 8'hA8;
    localparam logic [7:0]  LAST_ROW       = 8'hA7;
    localparam logic [4:0]  LAST_COL       = 5'h11;
    localparam logic [2:0]  LAST_BIT       = 3'h7;
    localparam logic [7:0]  WHITE_BYTE     = 8'hFF;
    localparam logic [7:0]  RESET_BYTE     = 8'h00;
    localparam logic [4:0]  RESET_COL      = 5'h00;
    localparam logic [2:0]  RESET_BITCNT   = 3'h0;
    localparam logic        RESET_LEVEL    = 1'b0;

    typedef enum logic [5:0] {
        MLSU_IDLE  = 6'b00_0001,
        MLSU_ADDR  = 6'b00_0010,
        MLSU_DATA  = 6'b00_0100,
        MLSU_TRAIL = 6'b00_1000,
        MLSU_CLEAR = 6'b01_0000,
        MLSU_SKIP  = 6'b10_0000
    } mlsu_state_t;
endpackage

/* design/mlsu_sync.sv */
/*
 * Two-stage synchroniser for a bundle of independent levels.
 * Assumes each bit is a slow level; no relation between bits is kept.
 */
`timescale 1ns/1ps
module mlsu_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sysClk,
    input  wire logic             resetN,
    input  wire logic             clkEn,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1;

    // stage1 feeds only the second flop
    always_ff @(posedge sysClk or negedge resetN) begin
        if (!resetN) begin
            stage1  <= '0;
            syncOut <= '0;
        end else if (clkEn) begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule

/* design/mlsu_fifo.sv */
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two; show-ahead read data.
 */
`timescale 1ns/1ps
module mlsu_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             sysClk,
    input  wire logic             resetN,
    input  wire logic             clkEn,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW:0]      wrPtr;
    logic [PW:0]      rdPtr;
    logic             full;
    logic             empty;

    assign empty    = (wrPtr == rdPtr);
    assign full     = (wrPtr[PW] != rdPtr[PW]) && (wrPtr[PW-1:0] == rdPtr[PW-1:0]);
    assign inReady  = !full;
    assign outValid = !empty;
    assign outData  = store[rdPtr[PW-1:0]];

    always_ff @(posedge sysClk) begin
        if (clkEn && inValid && !full) begin
            store[wrPtr[PW-1:0]] <= inData;
        end
    end

    always_ff @(posedge sysClk or negedge resetN) begin
        if (!resetN) begin
            wrPtr <= '0;
        end else if (clkEn && inValid && !full) begin
            wrPtr <= wrPtr + 1'b1;
        end
    end

    always_ff @(posedge sysClk or negedge resetN) begin
        if (!resetN) begin
            rdPtr <= '0;
        end else if (clkEn && outReady && !empty) begin
            rdPtr <= rdPtr + 1'b1;
        end
    end
endmodule

/* design/mlsu_serial_update.sv */
/*
 * Device side of the serial update interface: samples chip select, serial
 * clock and data, packs bytes into a FIFO, decodes header and line frames,
 * keeps the pixel memory and drives the common electrode level.
 * Assumes all host pins are asynchronous and the serial clock is at least
 * eight times slower than sysClk; the panel scan reads memory on scanRow/scanCol.
 */
`timescale 1ns/1ps
module mlsu_serial_update (
    input  wire logic       sysClk,
    input  wire logic       reset_n,
    input  wire logic       clkEn,
    input  wire logic       serialChipSelect,
    input  wire logic       serialClock,
    input  wire logic       serialData,
    input  wire logic       comSourceSelect,
    input  wire logic       externalComToggle,
    input  wire logic [7:0] scanRow,
    input  wire logic [4:0] scanCol,
    output logic      [7:0] scanData,
    output logic            commonElectrodeLevel,
    output logic            updateModeFlag,
    output logic            allClearFlag,
    output logic            engineBusy,
    output logic            rxOverrun
);
    // synchronised pins: {toggle, select, cs, sclk, sdata}
    logic [4:0] pinSync;
    logic [4:0] pinDly;
    logic       csNow;
    logic       sclkNow;
    logic       sdataNow;
    logic       comSelNow;
    logic       toggleNow;
    logic       csRise;
    logic       csFall;
    logic       sclkRise;
    logic       toggleRise;

    // receiver
    logic [7:0] shiftReg;
    logic [2:0] bitCnt;
    logic       pushValid;
    logic [8:0] pushWord;
    logic       pushReady;

    // engine
    logic       popValid;
    logic       popReady;
    logic [8:0] popWord;
    logic       popFire;
    logic       popMark;
    logic [7:0] popByte;
    mlsu_pkg::mlsu_state_t state;
    mlsu_pkg::mlsu_state_t next_state;
    logic [7:0] lineLatch [mlsu_pkg::LINE_BYTES];
    logic [4:0] dataCol;
    logic [7:0] lineAddr;
    logic       headerTaken;

    // transfer and clear
    logic       xferBusy;
    logic [7:0] xferRow;
    logic [4:0] xferCol;
    logic [7:0] clrRow;
    logic [4:0] clrCol;
    logic       memWe;
    logic [7:0] memRow;
    logic [4:0] memCol;
    logic [7:0] memData;
    logic [7:0] pixelMem [mlsu_pkg::LINE_COUNT][mlsu_pkg::LINE_BYTES];

    // polarity
    logic       togglePending;

    function automatic logic addrValid(input logic [7:0] a);
        addrValid = (a >= mlsu_pkg::FIRST_LINE) && (a <= mlsu_pkg::LAST_LINE);
    endfunction

    function automatic logic cellValid(input logic [7:0] r, input logic [4:0] c);
        cellValid = (r <= mlsu_pkg::LAST_ROW) && (c <= mlsu_pkg::LAST_COL);
    endfunction

    mlsu_sync #(
        .WIDTH   (5)
    ) u_sync (
        .sysClk  (sysClk),
        .resetN  (reset_n),
        .clkEn   (clkEn),
        .asyncIn ({externalComToggle, comSourceSelect, serialChipSelect, serialClock, serialData}),
        .syncOut (pinSync)
    );

    assign sdataNow  = pinSync[0];
    assign sclkNow   = pinSync[1];
    assign csNow     = pinSync[2];
    assign comSelNow = pinSync[3];
    assign toggleNow = pinSync[4];

    always_ff @(posedge sysClk or negedge reset_n) begin
        if (!reset_n) begin
            pinDly <= '0;
        end else if (clkEn) begin
            pinDly <= pinSync;
        end
    end

    assign csRise     = csNow && !pinDly[2];
    assign csFall     = !csNow && pinDly[2];
    assign sclkRise   = sclkNow && !pinDly[1];
    assign toggleRise = toggleNow && !pinDly[4];

    // bits arrive lsb first, so the first bit lands in bit 0
    always_ff @(posedge sysClk or negedge reset_n) begin
        if (!reset_n) begin
            shiftReg <= mlsu_pkg::RESET_BYTE;
            bitCnt   <= mlsu_pkg::RESET_BITCNT;
        end else if (clkEn) begin
            if (csRise) begin
                bitCnt <= mlsu_pkg::RESET_BITCNT;
            end else if (csNow && sclkRise) begin
                shiftReg <= {sdataNow, shiftReg[7:1]};
                bitCnt   <= bitCnt + 3'h1;
            end
        end
    end

    // end-of-frame marker rides the FIFO so flags clear in stream order
    always_ff @(posedge sysClk or negedge reset_n) begin
        if (!reset_n) begin
            pushValid <= 1'b0;
            pushWord  <= '0;
        end else if (clkEn) begin
            pushValid <= 1'b0;
            if (csFall) begin
                pushValid <= 1'b1;
                pushWord  <= {1'b1, mlsu_pkg::RESET_BYTE};
            end else if (csNow && sclkRise && bitCnt == mlsu_pkg::LAST_BIT) begin
                pushValid <= 1'b1;
                pushWord  <= {1'b0, sdataNow, shiftReg[7:1]};
            end
        end
    end

    // the serial link cannot stall, so a refused byte is reported instead
    always_ff @(posedge sysClk or negedge reset_n) begin
        if (!reset_n) begin
            rxOverrun <= 1'b0;
        end else if (clkEn) begin
            if (pushValid && !pushReady) begin
                rxOverrun <= 1'b1;
            end else if (csRise) begin
                rxOverrun <= 1'b0;
            end
        end
    end

    mlsu_fifo #(
        .WIDTH    (mlsu_pkg::FIFO_WIDTH),
        .DEPTH    (mlsu_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sysClk   (sysClk),
        .resetN   (reset_n),
        .clkEn    (clkEn),
        .inValid  (pushValid),
        .inReady  (pushReady),
        .inData   (pushWord),
        .outValid (popValid),
        .outReady (popReady),
        .outData  (popWord)
    );

    assign popMark = popWord[mlsu_pkg::MARK_BIT];
    assign popByte = popWord[7:0];
    assign popFire = popValid && popReady;
    assign headerTaken = popFire && !popMark && (state == mlsu_pkg::MLSU_IDLE);

    // stalls: header waits for a running transfer, data waits for the latch
    always_comb begin
        popReady = 1'b0;
        unique case (state)
            mlsu_pkg::MLSU_IDLE:  popReady = !xferBusy;
            mlsu_pkg::MLSU_ADDR:  popReady = 1'b1;
            mlsu_pkg::MLSU_DATA:  popReady = !xferBusy || popMark;
            mlsu_pkg::MLSU_TRAIL: popReady = 1'b1;
            mlsu_pkg::MLSU_CLEAR: popReady = 1'b0;
            mlsu_pkg::MLSU_SKIP:  popReady = 1'b1;
        endcase
    end

    always_comb begin
        next_state = state;
        unique case (state)
            mlsu_pkg::MLSU_IDLE: begin
                if (headerTaken) begin
                    if (popByte[mlsu_pkg::HDR_UPDATE_BIT]) begin
                        next_state = mlsu_pkg::MLSU_ADDR;
                    end else if (popByte[mlsu_pkg::HDR_CLEAR_BIT]) begin
                        next_state = mlsu_pkg::MLSU_CLEAR;
                    end else begin
                        next_state = mlsu_pkg::MLSU_SKIP;
                    end
                end
            end
            mlsu_pkg::MLSU_ADDR: begin
                if (popFire) begin
                    next_state = popMark ? mlsu_pkg::MLSU_IDLE : mlsu_pkg::MLSU_DATA;
                end
            end
            mlsu_pkg::MLSU_DATA: begin
                if (popFire && popMark) begin
                    next_state = mlsu_pkg::MLSU_IDLE;
                end else if (popFire && dataCol == mlsu_pkg::LAST_COL) begin
                    next_state = mlsu_pkg::MLSU_TRAIL;
                end
            end
            mlsu_pkg::MLSU_TRAIL: begin
                if (popFire) begin
                    next_state = popMark ? mlsu_pkg::MLSU_IDLE : mlsu_pkg::MLSU_ADDR;
                end
            end
            mlsu_pkg::MLSU_CLEAR: begin
                if (clrRow == mlsu_pkg::LAST_ROW && clrCol == mlsu_pkg::LAST_COL) begin
                    next_state = mlsu_pkg::MLSU_SKIP;
                end
            end
            mlsu_pkg::MLSU_SKIP: begin
                if (popFire && popMark) begin
                    next_state = mlsu_pkg::MLSU_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sysClk or negedge reset_n) begin
        if (!reset_n) begin
            state <= mlsu_pkg::MLSU_IDLE;
        end else if (clkEn) begin
            state <= next_state;
        end
    end

    always_ff @(posedge sysClk or negedge reset_n) begin
        if (!reset_n) begin
            engineBusy <= 1'b0;
        end else if (clkEn) begin
            engineBusy <= (next_state != mlsu_pkg::MLSU_IDLE) || xferBusy;
        end
    end

    // flags live until the frame's end marker is drained
    always_ff @(posedge sysClk or negedge reset_n) begin
        if (!reset_n) begin
            updateModeFlag <= 1'b0;
            allClearFlag   <= 1'b0;
        end else if (clkEn) begin
            if (headerTaken) begin
                updateModeFlag <= popByte[mlsu_pkg::HDR_UPDATE_BIT];
                allClearFlag   <= popByte[mlsu_pkg::HDR_CLEAR_BIT];
            end else if (popFire && popMark) begin
                updateModeFlag <= 1'b0;
                allClearFlag   <= 1'b0;
            end
        end
    end

    always_ff @(posedge sysClk or negedge reset_n) begin
        if (!reset_n) begin
            lineAddr <= mlsu_pkg::RESET_BYTE;
            dataCol  <= mlsu_pkg::RESET_COL;
        end else if (clkEn && popFire && !popMark) begin
            if (state == mlsu_pkg::MLSU_ADDR) begin
                lineAddr <= popByte;
                dataCol  <= mlsu_pkg::RESET_COL;
            end else if (state == mlsu_pkg::MLSU_DATA) begin
                dataCol  <= dataCol + 5'h01;
            end
        end
    end

    // first-stage latch: memory is untouched until the transfer
    always_ff @(posedge sysClk) begin
        if (clkEn && popFire && !popMark && state == mlsu_pkg::MLSU_DATA) begin
            lineLatch[dataCol] <= popByte;
        end
    end

    // transfer starts after the line's dummy byte and overlaps the next address
    always_ff @(posedge sysClk or negedge reset_n) begin
        if (!reset_n) begin
            xferBusy <= 1'b0;
            xferRow  <= mlsu_pkg::RESET_BYTE;
            xferCol  <= mlsu_pkg::RESET_COL;
        end else if (clkEn) begin
            if (xferBusy) begin
                xferCol <= xferCol + 5'h01;
                if (xferCol == mlsu_pkg::LAST_COL) begin
                    xferBusy <= 1'b0;
                end
            end else if (popFire && !popMark && state == mlsu_pkg::MLSU_TRAIL
                         && updateModeFlag && addrValid(lineAddr)) begin
                xferBusy <= 1'b1;
                xferRow  <= lineAddr - mlsu_pkg::FIRST_LINE;
                xferCol  <= mlsu_pkg::RESET_COL;
            end
        end
    end

    always_ff @(posedge sysClk or negedge reset_n) begin
        if (!reset_n) begin
            clrRow <= mlsu_pkg::RESET_BYTE;
            clrCol <= mlsu_pkg::RESET_COL;
        end else if (clkEn) begin
            if (state != mlsu_pkg::MLSU_CLEAR) begin
                clrRow <= mlsu_pkg::RESET_BYTE;
                clrCol <= mlsu_pkg::RESET_COL;
            end else if (clrCol == mlsu_pkg::LAST_COL) begin
                clrCol <= mlsu_pkg::RESET_COL;
                clrRow <= clrRow + 8'h01;
            end else begin
                clrCol <= clrCol + 5'h01;
            end
        end
    end

    // transfer and clear never overlap: clear only starts from an idle header
    always_comb begin
        memWe   = 1'b0;
        memRow  = xferRow;
        memCol  = xferCol;
        memData = lineLatch[xferCol];
        if (state == mlsu_pkg::MLSU_CLEAR) begin
            memWe   = 1'b1;
            memRow  = clrRow;
            memCol  = clrCol;
            memData = mlsu_pkg::WHITE_BYTE;
        end else if (xferBusy) begin
            memWe   = 1'b1;
        end
    end

    always_ff @(posedge sysClk) begin
        if (clkEn && memWe && cellValid(memRow, memCol)) begin
            pixelMem[memRow][memCol] <= memData;
        end
    end

    always_ff @(posedge sysClk or negedge reset_n) begin
        if (!reset_n) begin
            scanData <= mlsu_pkg::RESET_BYTE;
        end else if (clkEn) begin
            scanData <= cellValid(scanRow, scanCol) ? pixelMem[scanRow][scanCol] : mlsu_pkg::RESET_BYTE;
        end
    end

    // toggle edges seen while selected wait for the chip-select fall
    always_ff @(posedge sysClk or negedge reset_n) begin
        if (!reset_n) begin
            togglePending <= 1'b0;
        end else if (clkEn) begin
            if (!comSelNow || csFall) begin
                togglePending <= csNow && toggleRise && comSelNow;
            end else if (csNow && toggleRise) begin
                togglePending <= 1'b1;
            end
        end
    end

    always_ff @(posedge sysClk or negedge reset_n) begin
        if (!reset_n) begin
            commonElectrodeLevel <= mlsu_pkg::RESET_LEVEL;
        end else if (clkEn) begin
            if (comSelNow) begin
                commonElectrodeLevel <= commonElectrodeLevel
                                        ^ (csFall && togglePending)
                                        ^ (!csNow && toggleRise);
            end else if (headerTaken) begin
                commonElectrodeLevel <= popByte[mlsu_pkg::HDR_POL_BIT];
            end
        end
    end
endmodule

/* verification/mlsu_serial_update_assertions.sv */
/* checker for the serial update block, sees only its top ports;
   assumes the bench keeps host edges well apart */
`timescale 1ns/1ps
module mlsu_checker (
    input wire logic       sysClk,
    input wire logic       reset_n,
    input wire logic       serialChipSelect,
    input wire logic       comSourceSelect,
    input wire logic       externalComToggle,
    input wire logic [7:0] scanRow,
    input wire logic [4:0] scanCol,
    input wire logic [7:0] scanData,
    input wire logic       commonElectrodeLevel,
    input wire logic       updateModeFlag,
    input wire logic       allClearFlag,
    input wire logic       engineBusy
);
    logic [11:0] csLowCnt;
    logic        pendTog;
    default clocking @(posedge sysClk); endclocking
    default disable iff (!reset_n);
    // saturates past the longest clear so the idle check fires every cycle for the rest of the gap
    always_ff @(posedge sysClk or negedge reset_n) begin
        if (!reset_n) csLowCnt <= 12'h000;
        else if (serialChipSelect) csLowCnt <= 12'h000;
        else if (csLowCnt != 12'hC1C) csLowCnt <= csLowCnt + 12'h001;
    end
    always_ff @(posedge sysClk or negedge reset_n) begin
        if (!reset_n) pendTog <= 1'b0;
        else if (!serialChipSelect) pendTog <= 1'b0;
        else if (externalComToggle) pendTog <= 1'b1;
    end
    sequence s_flip; $changed(commonElectrodeLevel); endsequence
    sequence s_idle_rise; $rose(externalComToggle) && !serialChipSelect && comSourceSelect; endsequence
    sequence s_fall_pend; $fell(serialChipSelect) && comSourceSelect && pendTog; endsequence
    property p_idle_quiet; csLowCnt == 12'hC1C |-> !updateModeFlag && !allClearFlag && !engineBusy; endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("flags up long after frame end");
    property p_flag_in_frame; $rose(updateModeFlag) || $rose(allClearFlag) |-> $past(serialChipSelect, 2); endproperty
    a_flag_in_frame: assert property (p_flag_in_frame) else $error("mode flag rose outside a frame");
    property p_clear_alone; allClearFlag |-> !updateModeFlag; endproperty
    a_clear_alone: assert property (p_clear_alone) else $error("clear flag with update flag");
    property p_busy_flags; updateModeFlag || allClearFlag |-> engineBusy; endproperty
    a_busy_flags: assert property (p_busy_flags) else $error("mode flag without busy");
    property p_serial_pol; s_flip |-> serialChipSelect || comSourceSelect; endproperty
    a_serial_pol: assert property (p_serial_pol) else $error("level moved outside frame");
    property p_ext_hold;
        comSourceSelect && $past(comSourceSelect, 6) && serialChipSelect && $past(serialChipSelect, 6)
            |-> $stable(commonElectrodeLevel);
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("level moved inside frame");
    property p_ext_idle; s_idle_rise |-> ##[1:8] s_flip; endproperty
    a_ext_idle: assert property (p_ext_idle) else $error("toggle rise not applied");
    property p_ext_cs_fall; s_fall_pend |-> ##[1:8] s_flip; endproperty
    a_ext_cs_fall: assert property (p_ext_cs_fall) else $error("pending toggle not applied");
    property p_scan_range; scanRow > 8'hA7 || scanCol > 5'h11 |=> scanData == 8'h00; endproperty
    a_scan_range: assert property (p_scan_range) else $error("out of range read not zero");
endmodule

/* verification/mlsu_host_model.sv */
/* host driving the serial link and the toggle pin;
   assumes tasks are called from the bench, moves pins at falling sysClk */
`timescale 1ns/1ps
module mlsu_host_model (
    input wire logic sysClk,
    output logic     serialChipSelect,
    output logic     serialClock,
    output logic     serialData,
    output logic     externalComToggle
);
    initial begin
        serialChipSelect = 1'b0;
        serialClock = 1'b0;
        serialData = 1'b0;
        externalComToggle = 1'b0;
    end
    // 800 ns serial clock, runs only inside frames
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            serialData = b[i];
            repeat (4) @(negedge sysClk);
            serialClock = 1'b1;
            repeat (4) @(negedge sysClk);
            serialClock = 1'b0;
        end
    endtask
    task automatic frame_start();
        @(negedge sysClk);
        serialChipSelect = 1'b1;
        repeat (6) @(negedge sysClk);
    endtask
    task automatic frame_end();
        repeat (4) @(negedge sysClk);
        serialChipSelect = 1'b0;
        // released line must not hold its last bit
        serialData = ~serialData;
        repeat (6) @(negedge sysClk);
    endtask
    task automatic pulse_toggle();
        @(negedge sysClk);
        externalComToggle = 1'b1;
        repeat (12) @(negedge sysClk);
        externalComToggle = 1'b0;
        repeat (12) @(negedge sysClk);
    endtask
endmodule

/* verification/memory_lcd_serial_update_test.sv */
/* self-checking bench for the serial update block;
   assumes the host model and checker files are compiled first */
`timescale 1ns/1ps
module memory_lcd_serial_update_test;
    logic       sysClk, reset_n, clkEn, serialChipSelect, serialClock, serialData;
    logic       comSourceSelect, externalComToggle, commonElectrodeLevel;
    logic       updateModeFlag, allClearFlag, engineBusy, rxOverrun;
    logic [7:0] scanRow, scanData;
    logic [4:0] scanCol;
    int         errorCnt = 0;
    int         checked = 0;

    mlsu_serial_update dut_u (.sysClk(sysClk), .reset_n(reset_n), .clkEn(clkEn),
        .serialChipSelect(serialChipSelect), .serialClock(serialClock), .serialData(serialData),
        .comSourceSelect(comSourceSelect), .externalComToggle(externalComToggle), .scanRow(scanRow),
        .scanCol(scanCol), .scanData(scanData), .commonElectrodeLevel(commonElectrodeLevel),
        .updateModeFlag(updateModeFlag), .allClearFlag(allClearFlag), .engineBusy(engineBusy),
        .rxOverrun(rxOverrun));
    mlsu_host_model host_u (.sysClk(sysClk), .serialChipSelect(serialChipSelect),
        .serialClock(serialClock), .serialData(serialData), .externalComToggle(externalComToggle));

    initial begin
        sysClk = 1'b0;
        forever #50 sysClk = ~sysClk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, errorCnt);
        if (errorCnt == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp1(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            errorCnt++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            errorCnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_mem(input logic [7:0] row, input logic [4:0] col, input logic [7:0] exp);
        @(negedge sysClk);
        scanRow = row;
        scanCol = col;
        @(negedge sysClk);
        cmp8("scanData", exp, scanData);
        scanRow = 8'hFF;
    endtask
    task automatic wait_idle();
        int n;
        repeat (8) @(negedge sysClk);
        for (n = 0; n < 4000 && (engineBusy !== 1'b0 || updateModeFlag !== 1'b0); n++) @(negedge sysClk);
        if (n == 4000) begin
            errorCnt++;
            $display("unexpected engineBusy: expected 0 seen %b", engineBusy);
            stop_test();
        end
    endtask
    task automatic send_line(input logic [7:0] addr, input logic [7:0] seed);
        host_u.send_byte(addr);
        for (int c = 0; c < 18; c++) host_u.send_byte(seed ^ 8'(c));
        host_u.send_byte(8'h00);
    endtask

    initial begin
        static logic [7:0] hdr [2] = '{8'h02, 8'h00};
        reset_n = 1'b0;
        clkEn = 1'b1;
        comSourceSelect = 1'b0;
        scanRow = 8'hFF;
        scanCol = 5'h00;
        repeat (2) @(negedge sysClk);
        reset_n = 1'b1;
        repeat (4) @(negedge sysClk);
        // all clear; bytes pile up in the buffer while memory is whitened
        host_u.frame_start();
        host_u.send_byte(8'h04);
        repeat (8) @(negedge sysClk);
        cmp1("allClearFlag", 1'b1, allClearFlag);
        cmp1("updateModeFlag", 1'b0, updateModeFlag);
        for (int i = 0; i < 50; i++) host_u.send_byte(8'h00);
        cmp1("rxOverrun", 1'b1, rxOverrun);
        host_u.frame_end();
        wait_idle();
        cmp1("allClearFlag", 1'b0, allClearFlag);
        chk_mem(8'h00, 5'h00, 8'hFF);
        chk_mem(8'hA7, 5'h11, 8'hFF);
        $display("all clear test done");
        // three lines back to back, the last one out of range
        host_u.frame_start();
        host_u.send_byte(8'h01);
        repeat (8) @(negedge sysClk);
        cmp1("updateModeFlag", 1'b1, updateModeFlag);
        cmp1("rxOverrun", 1'b0, rxOverrun);
        send_line(8'h01, 8'hA5);
        send_line(8'hA8, 8'h3C);
        send_line(8'hC8, 8'h5A);
        host_u.send_byte(8'h00);
        host_u.frame_end();
        wait_idle();
        cmp1("updateModeFlag", 1'b0, updateModeFlag);
        for (int c = 0; c < 18; c++) begin
            chk_mem(8'h00, 5'(c), 8'hA5 ^ 8'(c));
            chk_mem(8'hA7, 5'(c), 8'h3C ^ 8'(c));
        end
        chk_mem(8'h01, 5'h00, 8'hFF);
        chk_mem(8'hA8, 5'h00, 8'h00);
        // clock enable low: scan output must hold its last value
        @(negedge sysClk);
        clkEn = 1'b0;
        scanRow = 8'h00;
        scanCol = 5'h00;
        repeat (2) @(negedge sysClk);
        cmp8("scanData", 8'h00, scanData);
        clkEn = 1'b1;
        @(negedge sysClk);
        cmp8("scanData", 8'hA5, scanData);
        scanRow = 8'hFF;
        $display("multi line test done");
        // display mode with line bytes that must be ignored, serial polarity
        for (int k = 0; k < 2; k++) begin
            host_u.frame_start();
            host_u.send_byte(hdr[k]);
            send_line(8'h01, 8'h00);
            host_u.send_byte(8'h00);
            cmp1("commonElectrodeLevel", hdr[k][1], commonElectrodeLevel);
            host_u.frame_end();
            wait_idle();
            chk_mem(8'h00, 5'h03, 8'hA6);
        end
        $display("display mode test done");
        // external toggle: once between frames, once inside a frame
        @(negedge sysClk);
        comSourceSelect = 1'b1;
        host_u.pulse_toggle();
        cmp1("commonElectrodeLevel", 1'b1, commonElectrodeLevel);
        host_u.frame_start();
        host_u.send_byte(8'h00);
        host_u.pulse_toggle();
        host_u.send_byte(8'h00);
        cmp1("commonElectrodeLevel", 1'b1, commonElectrodeLevel);
        host_u.frame_end();
        cmp1("commonElectrodeLevel", 1'b0, commonElectrodeLevel);
        wait_idle();
        // gap longer than the longest clear lets the idle check see quiet outputs
        repeat (3110) @(negedge sysClk);
        cmp1("engineBusy", 1'b0, engineBusy);
        $display("external polarity test done");
        stop_test();
    end
endmodule

bind mlsu_serial_update mlsu_checker chk_u (.sysClk, .reset_n, .serialChipSelect, .comSourceSelect,
    .externalComToggle, .scanRow, .scanCol, .scanData, .commonElectrodeLevel, .updateModeFlag,
    .allClearFlag, .engineBusy);
